// ==== shared/nsfm_cfg.svh ====
/*
  Constants of the normal-state fault manager: clock rate, timing counts,
  register offsets, field positions and reset values.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef NSFM_CFG_SVH
`define NSFM_CFG_SVH

// Clock rate and derived timing.
`define CLK_MHZ 100
`define ERR_PULSE_US 50
`define ERR_PULSE_CYC (`ERR_PULSE_US * `CLK_MHZ)
`define WD_TICK_US 1000
`define WD_TICK_CYC (`WD_TICK_US * `CLK_MHZ)
`define BLANK_DEG_NS 2000
`define BLANK_DEG_CYC ((`BLANK_DEG_NS * `CLK_MHZ + 999) / 1000)

// Register byte addresses.
`define REG_CTRL 8'h00
`define REG_MASK 8'h04
`define REG_FLAGS 8'h08
`define REG_CH_EN 8'h0c
`define REG_DIAG_EN 8'h10
`define REG_OPEN 8'h14
`define REG_SHORT 8'h18
`define REG_SLS 8'h1c
`define REG_STATUS 8'h20

// Control register fields.
`define CTRL_FAULT_CLR 0
`define CTRL_POR_CLR 1
`define CTRL_FS_CLR 2
`define CTRL_WD_LSB 8
`define CTRL_SLS_EN 12

// Mask register fields.
`define MASK_LOWSUP 0
`define MASK_SUPUV 1
`define MASK_REF 2
`define MASK_PRETSD 3
`define MASK_TSD 4
`define MASK_CRC 5
`define MASK_OPEN 6
`define MASK_SHORT 7
`define MASK_SLS 8

// Reset values.
`define WD_PERIOD_RST 4'h0
`define MASK_RST 9'h000
`define SLS_EN_RST 1'b0

`endif

// ==== shared/nsfm_pkg.sv ====
/*
  Types of the normal-state fault manager.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nsfm_pkg;

  // Device operating state, one-hot.
  typedef enum logic [3:0] {
    ST_POR = 4'b0001,
    ST_INIT = 4'b0010,
    ST_NORMAL = 4'b0100,
    ST_FAILSAFE = 4'b1000
  } mgr_state_t;

endpackage

// ==== verilog/err_pulse_gen.sv ====
/*
  One-shot timer that stretches a trigger into a fixed-length error pulse.
  Assumes a trigger from the same clock; triggers during a pulse are dropped.
*/
`timescale 1ns/1ps
module err_pulse_gen #(
  parameter int CYC = 5000,
  parameter int W = 20
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Trigger and pulse.
  input wire logic i_trigger,
  output logic o_busy
);

  localparam logic [W-1:0] LOAD = W'(CYC);

  logic [W-1:0] cnt_q;

  // A pulse already running is not extended, so a burst shorter than the pulse gives one pulse.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end else if (i_trigger) begin
      cnt_q <= LOAD;
    end
  end

  assign o_busy = (cnt_q != '0);

endmodule

// ==== verilog/normal_state_fault_manager.sv ====
/*
  Fault manager of a multi-channel LED driver in its normal state: latches
  fault flags, drives the open-drain error pin, gates outputs, runs the
  communication watchdog and holds the control, mask and enable registers.
  Assumes synchronous single-cycle register strobes, comparator levels from
  the analog side (asynchronous) and frame, PWM and checksum signals from
  logic on i_mclk.
*/
`timescale 1ns/1ps
`include "nsfm_cfg.svh"
module normal_state_fault_manager #(
  parameter int N = 24,
  parameter int ERR_PULSE_CYC = `ERR_PULSE_CYC,
  parameter int WD_TICK_CYC = `WD_TICK_CYC
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port.
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Analog comparator levels, asynchronous.
  input wire logic i_por_fault,
  input wire logic i_low_supply,
  input wire logic i_supply_uv,
  input wire logic i_ref_fault,
  input wire logic i_prethermal,
  input wire logic i_overtemp,
  input wire logic [N-1:0] i_open_cmp,
  input wire logic [N-1:0] i_short_cmp,
  input wire logic [N-1:0] i_sls_cmp,
  // Channel PWM on-phase, same clock.
  input wire logic [N-1:0] i_pwm_on,
  // Configuration checksum, same clock.
  input wire logic i_crc_check_done,
  input wire logic [7:0] i_computed_config_checksum,
  input wire logic [7:0] i_stored_config_checksum,
  // Frame results from the serial decoder, same clock.
  input wire logic i_frame_done,
  input wire logic i_frame_crc_ok,
  input wire logic i_frame_addr_match,
  input wire logic i_frame_bcast,
  // Open-drain error pin.
  input wire logic i_err_pin,
  output logic o_err_o,
  output logic o_err_oe,
  // Device controls.
  output logic o_outputs_off,
  output logic o_diag_suspend,
  output nsfm_pkg::mgr_state_t o_state
);
  import nsfm_pkg::*;

  localparam int SW = 7 + 3 * N;
  localparam logic [15:0] BLANK_DEG = 16'(`BLANK_DEG_CYC);
  localparam logic [31:0] TICK_LAST = 32'(WD_TICK_CYC - 1);

  // Two-stage synchroniser for every asynchronous level.
  logic [SW-1:0] sync1_q, sync2_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_err_pin, i_sls_cmp, i_short_cmp, i_open_cmp, i_overtemp,
                  i_prethermal, i_ref_fault, i_supply_uv, i_low_supply, i_por_fault};
      sync2_q <= sync1_q;
    end
  end

  wire s_por = sync2_q[0];
  wire s_low = sync2_q[1];
  wire s_uv = sync2_q[2];
  wire s_ref = sync2_q[3];
  wire s_pre = sync2_q[4];
  wire s_tsd = sync2_q[5];
  wire [N-1:0] s_open = sync2_q[6 +: N];
  wire [N-1:0] s_short = sync2_q[6 + N +: N];
  wire [N-1:0] s_sls = sync2_q[6 + 2 * N +: N];
  wire s_err_pin = sync2_q[SW-1];

  // Software-visible registers and internal edge, watchdog, read and output state.
  mgr_state_t state_q, state_d;
  logic [3:0] wd_period_q;
  logic sls_en_q;
  logic [8:0] mask_q;
  logic [N-1:0] ch_en_q, diag_en_q;
  logic [N-1:0] open_flag_q, short_flag_q, sls_flag_q;
  logic por_flag_q, err_flag_q, out_flag_q, low_flag_q, uv_flag_q;
  logic ref_flag_q, pre_flag_q, tsd_flag_q, crc_flag_q, fs_flag_q;
  logic low_prev_q, pre_prev_q;
  logic [31:0] tick_q;
  logic [3:0] wd_cnt_q;
  logic [31:0] rdata_q;
  logic err_oe_q, outputs_off_q, diag_suspend_q;

  // Register decode; command bits act once and are never stored.
  wire wr_ctrl = i_wr && (i_addr == `REG_CTRL);
  wire fclr = wr_ctrl && i_wdata[`CTRL_FAULT_CLR];
  wire pclr = wr_ctrl && i_wdata[`CTRL_POR_CLR];
  wire fsclr = wr_ctrl && i_wdata[`CTRL_FS_CLR];
  wire in_por = (state_q == ST_POR);
  wire in_normal = (state_q == ST_NORMAL);
  wire live = !in_por;

  wire m_low = mask_q[`MASK_LOWSUP];
  wire m_uv = mask_q[`MASK_SUPUV];
  wire m_ref = mask_q[`MASK_REF];
  wire m_pre = mask_q[`MASK_PRETSD];
  wire m_tsd = mask_q[`MASK_TSD];
  wire m_crc = mask_q[`MASK_CRC];
  wire m_open = mask_q[`MASK_OPEN];
  wire m_short = mask_q[`MASK_SHORT];
  wire m_sls = mask_q[`MASK_SLS];

  // Per-channel on-time qualification against blanking plus deglitch.
  wire [N-1:0] on_long;
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ch
      logic [15:0] cnt_q;
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          cnt_q <= '0;
        end else if (!i_pwm_on[gi]) begin
          cnt_q <= '0;
        end else if (cnt_q < BLANK_DEG) begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
      assign on_long[gi] = (cnt_q >= BLANK_DEG);
    end
  endgenerate

  // Channel fault judgement; low supply blocks open and single-LED checks.
  wire [N-1:0] judge = ch_en_q & diag_en_q & on_long & {N{in_normal}};
  wire [N-1:0] open_hit = judge & s_open & {N{!s_low}};
  wire [N-1:0] short_hit = judge & s_short;
  wire [N-1:0] sls_hit = judge & s_sls & {N{sls_en_q && !s_low}};
  wire [N-1:0] open_new = open_hit & ~open_flag_q;
  wire [N-1:0] short_new = short_hit & ~short_flag_q;
  wire [N-1:0] sls_new = sls_hit & ~sls_flag_q;

  // Masks gate only the summary flags and the pin pulldown, pulsed or constant.
  wire out_set = ((|open_hit) && !m_open) || ((|short_hit) && !m_short) ||
                 ((|sls_hit) && !m_sls);
  wire ch_pulse = ((|open_new) && !m_open) || ((|short_new) && !m_short) ||
                  ((|sls_new) && !m_sls);
  wire crc_evt = live && i_crc_check_done &&
                 (i_computed_config_checksum != i_stored_config_checksum);
  wire low_rise = s_low && !low_prev_q;
  wire pre_rise = s_pre && !pre_prev_q;

  wire err_set = live && ((s_low && !m_low) || (s_uv && !m_uv) || (s_ref && !m_ref) ||
                          (s_pre && !m_pre) || (s_tsd && !m_tsd) || out_set) ||
                 (crc_evt && !m_crc);
  wire pulse_trig = live && ((low_rise && !m_low) || (pre_rise && !m_pre) ||
                             (crc_evt && !m_crc) || ch_pulse);
  wire const_pull = in_por || (live && ((s_uv && !m_uv) || (s_ref && !m_ref) ||
                                        (s_tsd && !m_tsd)));
  wire pulse_busy;

  err_pulse_gen #(
    .CYC(ERR_PULSE_CYC),
    .W(32)
  ) u_pulse (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_trigger(pulse_trig),
    .o_busy(pulse_busy)
  );

  // Watchdog: restarted by good frames addressed to this device, never by broadcasts; idle when the period is zero.
  wire kick = i_frame_done && i_frame_crc_ok && i_frame_addr_match && !i_frame_bcast;
  wire wd_run = in_normal && (wd_period_q != 4'h0);
  wire tick_end = (tick_q == TICK_LAST);
  wire wd_over = wd_run && !kick && tick_end && ((wd_cnt_q + 4'h1) == wd_period_q);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tick_q <= '0;
      wd_cnt_q <= 4'h0;
    end else if (!wd_run || kick || wd_over) begin
      tick_q <= '0;
      wd_cnt_q <= 4'h0;
    end else if (tick_end) begin
      tick_q <= '0;
      wd_cnt_q <= wd_cnt_q + 4'h1;
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end

  // State sequence; rail loss wins over everything else.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_POR: begin
        if (!s_por) state_d = ST_INIT;
      end
      ST_INIT: state_d = ST_NORMAL;
      ST_NORMAL: begin
        if (wd_over) state_d = ST_FAILSAFE;
      end
      ST_FAILSAFE: begin
        if (fsclr) state_d = ST_NORMAL;
      end
      default: state_d = ST_POR;
    endcase
    if (s_por) state_d = ST_POR;
  end

  // Configuration registers written by software.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wd_period_q <= `WD_PERIOD_RST;
      sls_en_q <= `SLS_EN_RST;
      mask_q <= `MASK_RST;
      ch_en_q <= '0;
      diag_en_q <= '0;
    end else if (i_wr) begin
      if (wr_ctrl) begin
        wd_period_q <= i_wdata[`CTRL_WD_LSB +: 4];
        sls_en_q <= i_wdata[`CTRL_SLS_EN];
      end
      if (i_addr == `REG_MASK) mask_q <= i_wdata[8:0];
      if (i_addr == `REG_CH_EN) ch_en_q <= i_wdata[N-1:0];
      if (i_addr == `REG_DIAG_EN) diag_en_q <= i_wdata[N-1:0];
    end
  end

  // Latched flags: a set in the same cycle as a clear wins; power-on empties them but sets the power-on and error flags.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_POR;
      por_flag_q <= 1'b1;
      err_flag_q <= 1'b1;
      {out_flag_q, low_flag_q, uv_flag_q, ref_flag_q, pre_flag_q} <= 5'h00;
      {tsd_flag_q, crc_flag_q, fs_flag_q} <= 3'h0;
      open_flag_q <= '0;
      short_flag_q <= '0;
      sls_flag_q <= '0;
      low_prev_q <= 1'b0;
      pre_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      low_prev_q <= s_low;
      pre_prev_q <= s_pre;
      por_flag_q <= in_por || (por_flag_q && !pclr);
      err_flag_q <= in_por || err_set || (err_flag_q && !pclr && !fclr);
      out_flag_q <= live && (out_set || (out_flag_q && !fclr));
      low_flag_q <= live && (s_low || (low_flag_q && !fclr));
      uv_flag_q <= live && (s_uv || (uv_flag_q && !fclr));
      ref_flag_q <= live && (s_ref || (ref_flag_q && !fclr));
      pre_flag_q <= live && (s_pre || (pre_flag_q && !fclr));
      tsd_flag_q <= live && (s_tsd || (tsd_flag_q && !fclr));
      crc_flag_q <= live && (crc_evt || (crc_flag_q && !fclr));
      fs_flag_q <= live && (wd_over || (fs_flag_q && !fsclr));
      open_flag_q <= {N{live}} & (open_hit | (open_flag_q & ~{N{fclr}}));
      short_flag_q <= {N{live}} & (short_hit | (short_flag_q & ~{N{fclr}}));
      sls_flag_q <= {N{live}} & (sls_hit | (sls_flag_q & ~{N{fclr}}));
    end
  end

  // Pin and output controls; undervoltage and overheat switch the outputs off whatever the masks.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      err_oe_q <= 1'b1;
      outputs_off_q <= 1'b1;
      diag_suspend_q <= 1'b0;
    end else begin
      err_oe_q <= const_pull || pulse_busy;
      outputs_off_q <= !in_normal && !(state_q == ST_FAILSAFE) || s_uv || s_tsd;
      diag_suspend_q <= s_low;
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  wire [31:0] flags_word = {22'h0, fs_flag_q, crc_flag_q, tsd_flag_q, pre_flag_q,
                            ref_flag_q, uv_flag_q, low_flag_q, out_flag_q,
                            err_flag_q, por_flag_q};
  wire [31:0] ctrl_word = {19'h0, sls_en_q, wd_period_q, 8'h00};
  wire [31:0] status_word = {20'h0, s_err_pin, s_tsd, s_pre, s_ref, s_uv, s_low,
                             s_por, pulse_busy, state_q};
  wire [31:0] rd_mux =
    (i_addr == `REG_CTRL) ? ctrl_word :
    (i_addr == `REG_MASK) ? {23'h0, mask_q} :
    (i_addr == `REG_FLAGS) ? flags_word :
    (i_addr == `REG_CH_EN) ? 32'(ch_en_q) :
    (i_addr == `REG_DIAG_EN) ? 32'(diag_en_q) :
    (i_addr == `REG_OPEN) ? 32'(open_flag_q) :
    (i_addr == `REG_SHORT) ? 32'(short_flag_q) :
    (i_addr == `REG_SLS) ? 32'(sls_flag_q) :
    (i_addr == `REG_STATUS) ? status_word : 32'h0000_0000;

  // Read data stands for exactly one cycle after the strobe.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_q;
  assign o_err_o = 1'b0; // Open drain only ever pulls low.
  assign o_err_oe = err_oe_q;
  assign o_outputs_off = outputs_off_q;
  assign o_diag_suspend = diag_suspend_q;
  assign o_state = state_q;

endmodule

// ==== bench/serial_host_model.sv ====
/*
  Frame source standing in for the serial decoder fed by the host controller.
  Assumes the bench asks for one frame at a time by a one-cycle send request.
*/
`timescale 1ns/1ps
module serial_host_model (
  // Clock.
  input wire logic i_mclk,
  // Requests from the bench.
  input wire logic i_send,
  input wire logic i_bcast,
  // Frame result towards the device.
  output logic o_done,
  output logic o_crc_ok,
  output logic o_match,
  output logic o_bcast
);
  logic tog_q = 1'b0;

  // Qualifiers mean something only beside the done pulse, so between frames they toggle.
  always @(posedge i_mclk) begin
    tog_q <= !tog_q;
    o_done <= i_send;
    o_crc_ok <= i_send ? 1'b1 : tog_q;
    o_match <= i_send ? 1'b1 : !tog_q;
    o_bcast <= i_send ? i_bcast : tog_q;
  end
endmodule

// ==== bench/nsfm_asserts.sv ====
/*
  Port checker of the fault manager, bound into every instance.
  Assumes the register map of the shared constants and one clock domain.
*/
`timescale 1ns/1ps
`include "nsfm_cfg.svh"
module nsfm_asserts
  import nsfm_pkg::*;
#(
  parameter int ERR_PULSE_CYC = 20
) (
  // Clock, reset and register port.
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Fault levels and frame results.
  input wire logic i_por_fault,
  input wire logic i_low_supply,
  input wire logic i_supply_uv,
  input wire logic i_ref_fault,
  input wire logic i_overtemp,
  input wire logic i_frame_done,
  input wire logic i_frame_crc_ok,
  input wire logic i_frame_addr_match,
  input wire logic i_frame_bcast,
  // Device outputs.
  input wire logic o_err_oe,
  input wire logic o_outputs_off,
  input wire logic o_diag_suspend,
  input wire nsfm_pkg::mgr_state_t o_state
);
  logic [8:0] msk_q;
  logic [3:0] wdp_q;
  logic [15:0] hi_q;
  logic cst_q;
  wire kick = i_frame_done && i_frame_crc_ok && i_frame_addr_match && !i_frame_bcast;
  wire cst = i_por_fault || i_supply_uv || i_ref_fault || i_overtemp;

  // Shadow mask and period; a pulse is timed only when no level fault shared the pin.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      msk_q <= `MASK_RST;
      wdp_q <= `WD_PERIOD_RST;
      hi_q <= 16'h0000;
      cst_q <= 1'b1;
    end else begin
      if (i_wr && i_addr == `REG_MASK) msk_q <= i_wdata[8:0];
      if (i_wr && i_addr == `REG_CTRL) wdp_q <= i_wdata[`CTRL_WD_LSB +: 4];
      hi_q <= o_err_oe ? hi_q + 16'h0001 : 16'h0000;
      cst_q <= (o_err_oe && cst_q) || cst;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  sequence s_kick;
    o_state == ST_NORMAL && kick;
  endsequence
  sequence s_fs_clr;
    o_state == ST_FAILSAFE && i_wr && i_addr == `REG_CTRL && i_wdata[`CTRL_FS_CLR];
  endsequence

  chk_por_holds: assert property (i_por_fault [*5] |->
    o_state == ST_POR && o_err_oe && o_outputs_off) else $error("por state not held");
  chk_suspend_follows: assert property ($stable(i_low_supply) [*4] |->
    o_diag_suspend == i_low_supply) else $error("diag suspend wrong");
  chk_uv_off: assert property (i_supply_uv [*5] |->
    o_outputs_off && (o_err_oe || msk_q[`MASK_SUPUV])) else $error("uv response wrong");
  chk_ref_pin: assert property (i_ref_fault [*6] ##0 !msk_q[`MASK_REF] |-> o_err_oe)
    else $error("ref fault pin not low");
  chk_tsd_off: assert property (i_overtemp [*5] |->
    o_outputs_off && (o_err_oe || msk_q[`MASK_TSD])) else $error("tsd response wrong");
  chk_pulse_len: assert property ($fell(o_err_oe) && !cst_q |->
    hi_q == ERR_PULSE_CYC) else $error("error pulse length wrong");
  chk_fs_exit: assert property (s_fs_clr |=> o_state == ST_NORMAL)
    else $error("failsafe not left");
  chk_clear_zero: assert property (i_rd && i_addr == `REG_CTRL |=>
    o_rdata[`CTRL_FAULT_CLR] == 1'b0) else $error("fault clear reads one");
  chk_kick_holds: assert property (s_kick |=> (o_state == ST_NORMAL) [*8])
    else $error("watchdog overflow after kick");
  chk_wd_off: assert property (wdp_q == 4'h0 && o_state == ST_NORMAL |=>
    o_state != ST_FAILSAFE) else $error("disabled watchdog fired");
endmodule

bind normal_state_fault_manager nsfm_asserts #(.ERR_PULSE_CYC(ERR_PULSE_CYC)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_por_fault(i_por_fault), .i_low_supply(i_low_supply),
  .i_supply_uv(i_supply_uv), .i_ref_fault(i_ref_fault), .i_overtemp(i_overtemp),
  .i_frame_done(i_frame_done), .i_frame_crc_ok(i_frame_crc_ok),
  .i_frame_addr_match(i_frame_addr_match), .i_frame_bcast(i_frame_bcast),
  .o_err_oe(o_err_oe), .o_outputs_off(o_outputs_off), .o_diag_suspend(o_diag_suspend),
  .o_state(o_state));

// ==== bench/normal_state_fault_manager_tb.sv ====
/*
  Self-checking bench of the fault manager: register tasks, fault tables and frames.
  Assumes the bound checker and the frame source model; pulse and tick counts shortened.
*/
`timescale 1ns/1ps
`include "nsfm_cfg.svh"
module normal_state_fault_manager_tb;
  import nsfm_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] flt = 6'h00;
  logic [3:0] cmp = 4'h0;
  logic [3:0] pwm = 4'h0;
  logic crc = 1'b0;
  logic [7:0] calc = 8'h5a;
  logic snd = 1'b0;
  logic bc = 1'b0;
  logic fd, fok, fm, fb, err_o, err_oe, off, susp;
  logic [31:0] rdata;
  mgr_state_t st;
  int error_cnt = 0;
  int num_checks = 0;
  int k, m, hi;
  // Open-drain pin with pull-up: low only while the device pulls it.
  wire pin = err_oe ? err_o : 1'b1;

  normal_state_fault_manager #(.N(4), .ERR_PULSE_CYC(20), .WD_TICK_CYC(10)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_por_fault(flt[0]), .i_low_supply(flt[1]), .i_supply_uv(flt[2]),
    .i_ref_fault(flt[3]), .i_prethermal(flt[4]), .i_overtemp(flt[5]), .i_open_cmp(cmp),
    .i_short_cmp(cmp), .i_sls_cmp(cmp), .i_pwm_on(pwm), .i_crc_check_done(crc),
    .i_computed_config_checksum(calc), .i_stored_config_checksum(8'h5a),
    .i_frame_done(fd), .i_frame_crc_ok(fok), .i_frame_addr_match(fm), .i_frame_bcast(fb),
    .i_err_pin(pin), .o_err_o(err_o), .o_err_oe(err_oe), .o_outputs_off(off),
    .o_diag_suspend(susp), .o_state(st));
  serial_host_model host (.i_mclk(i_mclk), .i_send(snd), .i_bcast(bc), .o_done(fd),
    .o_crc_ok(fok), .o_match(fm), .o_bcast(fb));

  // Free-running 100 MHz clock.
  always #5 i_mclk = !i_mclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic wst(input mgr_state_t s);
    int i;
    for (i = 0; i < 20 && st !== s; i++) @(posedge i_mclk);
    chk(st, s);
    if (st !== s) report_and_stop();
  endtask

  // Counts pin pulldown cycles over a window long enough for one whole pulse.
  task automatic count_hi;
    hi = 0;
    repeat (40) @(posedge i_mclk) hi += err_oe;
  endtask

  task automatic kicks(input logic b);
    repeat (8) begin
      @(posedge i_mclk);
      snd <= 1'b1;
      bc <= b;
      @(posedge i_mclk);
      snd <= 1'b0;
      repeat (3) @(posedge i_mclk);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge i_mclk);
    chk(st, ST_POR);
    i_rst <= 1'b0;
    wst(ST_NORMAL);
    rc(`REG_FLAGS, 32'h3);
    for (k = 0; k < 8; k++) begin
      if (k != 2) rc(8'(k * 4), 32'h0);
    end
    rc(8'h3c, 32'h0);
    wr_reg(`REG_CTRL, 32'h2);
    rc(`REG_FLAGS, 32'h0);
    $display("test reset done");
    // Every analog fault but power-on, unmasked then masked; pulse kinds are timed, level kinds held.
    for (k = 1; k < 6; k++) begin
      for (m = 0; m < 2; m++) begin
        wr_reg(`REG_MASK, 32'(m) << (k - 1));
        @(posedge i_mclk) flt[k] <= 1'b1;
        count_hi();
        if (k == 1 || k == 4) chk(hi, m ? 0 : 20);
        else chk(err_oe, !m);
        chk(off, k == 2 || k == 5);
        chk(susp, k == 1);
        @(posedge i_mclk) flt[k] <= 1'b0;
        repeat (8) @(posedge i_mclk);
        chk(err_oe | off | susp, 0);
        rc(`REG_FLAGS, (32'h1 << (k + 2)) | (m ? 32'h0 : 32'h2));
        wr_reg(`REG_CTRL, 32'h1);
        rc(`REG_FLAGS, 32'h0);
      end
    end
    $display("test analog faults done");
    for (m = 0; m < 3; m++) begin
      wr_reg(`REG_MASK, (m == 2) ? 32'h20 : 32'h0);
      @(posedge i_mclk);
      calc <= (m == 0) ? 8'h5a : 8'ha5;
      crc <= 1'b1;
      @(posedge i_mclk) crc <= 1'b0;
      count_hi();
      chk(hi, (m == 1) ? 20 : 0);
      rc(`REG_FLAGS, (m == 0) ? 32'h0 : ((m == 1) ? 32'h102 : 32'h100));
      wr_reg(`REG_CTRL, 32'h1);
    end
    $display("test checksum done");
    wr_reg(`REG_MASK, 32'h0);
    wr_reg(`REG_CH_EN, 32'h5);
    wr_reg(`REG_DIAG_EN, 32'h3);
    rc(`REG_CH_EN, 32'h5);
    @(posedge i_mclk);
    cmp <= 4'hf;
    pwm <= 4'hf;
    repeat (150) @(posedge i_mclk);
    pwm <= 4'h0;
    rc(`REG_SHORT, 32'h0);
    @(posedge i_mclk) pwm <= 4'hf;
    repeat (250) @(posedge i_mclk);
    rc(`REG_SHORT, 32'h1);
    rc(`REG_OPEN, 32'h1);
    rc(`REG_SLS, 32'h0);
    rc(`REG_FLAGS, 32'h6);
    wr_reg(`REG_CTRL, 32'h1000);
    repeat (10) @(posedge i_mclk);
    rc(`REG_SLS, 32'h1);
    @(posedge i_mclk);
    cmp <= 4'h0;
    pwm <= 4'h0;
    wr_reg(`REG_CTRL, 32'h1);
    rc(`REG_FLAGS, 32'h0);
    rc(`REG_SHORT, 32'h0);
    $display("test channels done");
    chk(st, ST_NORMAL);
    wr_reg(`REG_CTRL, 32'h100);
    rc(`REG_CTRL, 32'h100);
    kicks(1'b0);
    chk(st, ST_NORMAL);
    kicks(1'b1);
    chk(st, ST_FAILSAFE);
    chk(err_oe, 0);
    chk(err_o, 0);
    rc(`REG_FLAGS, 32'h200);
    wr_reg(`REG_CTRL, 32'h4);
    wst(ST_NORMAL);
    rc(`REG_FLAGS, 32'h0);
    $display("test watchdog done");
    @(posedge i_mclk) flt[0] <= 1'b1;
    repeat (6) @(posedge i_mclk);
    chk({st, err_oe, off}, {ST_POR, 2'b11});
    @(posedge i_mclk) flt[0] <= 1'b0;
    wst(ST_NORMAL);
    rc(`REG_FLAGS, 32'h3);
    wr_reg(`REG_CTRL, 32'h2);
    rc(`REG_FLAGS, 32'h0);
    $display("test power loss done");
    report_and_stop();
  end
endmodule
